// ==== include/phy_assist_pkg.sv ====
// Purpose: shared constants and types for the PHY assist sideband
// Assumes: one clock mclk, asynchronous active-low reset rst_b
// Notes: lane count is a parameter of both ends; port widths are fixed in this package
package phy_assist_pkg;
  localparam int LANES = 1;
  localparam int RECONFIG_ADDR_W = 10;
  localparam int RECONFIG_DATA_W = 16;
  localparam int RECONFIG_WORDS = 1024;
  // receive power-state encoding
  localparam logic [1:0] RX_NOT_STANDBY = 2'h0;
  localparam logic [1:0] RX_STANDBY_ENTRY = 2'h1;
  localparam logic [1:0] RX_STANDBY_IDLE = 2'h2;
  localparam logic [1:0] RX_STANDBY_TRAINING = 2'h3;
  // reconfiguration access latency in clock cycles, from the edge that takes the enable to ready
  localparam int RECONFIG_LATENCY = 2;
  // power-good settle time after reset release
  localparam int POWER_OK_NS = 100;
  localparam int CLK_PERIOD_NS = 20;
  localparam int POWER_OK_CYCLES = (POWER_OK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [15:0] RECONFIG_RESET_WORD = 16'h0000;
  // link substates of the MAC, as driven by the MAC user side
  typedef enum logic [3:0] {
    LS_DETECT_QUIET, LS_DETECT_ACTIVE, LS_POLLING, LS_CONFIG, LS_L0,
    LS_RECOVERY, LS_RECOVERY_SPEED, LS_L1_ENTRY, LS_L1_IDLE,
    LS_LOOPBACK_ENTRY, LS_LOOPBACK_SPEED, LS_LOOPBACK_ACTIVE, LS_DISABLED
  } link_state_e;
  typedef enum logic [1:0] {TERM_TO_VTT, TERM_TO_GND} term_e;
endpackage : phy_assist_pkg

// ==== include/phy_assist_if.sv ====
// Purpose: sideband carrier between the soft MAC and the PHY wrapper
// Assumes: all signals sampled on mclk
// Notes: reconfiguration port signals are per lane, packed lane-major
`timescale 1ns/100ps
`default_nettype none
interface phy_assist_if #(
  parameter int LANES = phy_assist_pkg::LANES
) (
  input wire logic mclk,
  input wire logic rst_b
);
  logic mac_detect_state_flag;
  logic clock_recovery_hold_request;
  logic mac_link_active_flag;
  logic [1:0] rx_power_state_field;
  logic [LANES-1:0] transceiver_power_ok;
  logic [LANES*phy_assist_pkg::RECONFIG_ADDR_W-1:0] reconfig_addr;
  logic [LANES-1:0] reconfig_enable;
  logic [LANES-1:0] reconfig_write_select;
  logic [LANES*phy_assist_pkg::RECONFIG_DATA_W-1:0] reconfig_write_data;
  logic [LANES-1:0] reconfig_ready;
  logic [LANES*phy_assist_pkg::RECONFIG_DATA_W-1:0] reconfig_read_data;

  modport phy (
    input mclk, rst_b, mac_detect_state_flag, clock_recovery_hold_request,
    mac_link_active_flag, rx_power_state_field, reconfig_addr, reconfig_enable,
    reconfig_write_select, reconfig_write_data,
    output transceiver_power_ok, reconfig_ready, reconfig_read_data
  );
  modport mac (
    input mclk, rst_b, transceiver_power_ok, reconfig_ready, reconfig_read_data,
    output mac_detect_state_flag, clock_recovery_hold_request, mac_link_active_flag,
    rx_power_state_field, reconfig_addr, reconfig_enable, reconfig_write_select,
    reconfig_write_data
  );
endinterface : phy_assist_if
`default_nettype wire

// ==== rtl/phy_assist_mac_end.sv ====
// Purpose: MAC-side driver of the assist sideband and reconfiguration master
// Assumes: link_state comes from the MAC state machine on mclk
// Notes: outputs derived from the states this MAC implements
`timescale 1ns/100ps
`default_nettype none
module phy_assist_mac_end #(
  parameter int LANES = phy_assist_pkg::LANES
) (
  input wire logic mclk,
  input wire logic rst_b,
  phy_assist_if.mac link,
  input wire phy_assist_pkg::link_state_e link_state,
  input wire logic [1:0] rx_standby_state,
  input wire logic [LANES-1:0] req_valid,
  input wire logic [LANES-1:0] req_write,
  input wire logic [LANES*phy_assist_pkg::RECONFIG_ADDR_W-1:0] req_addr,
  input wire logic [LANES*phy_assist_pkg::RECONFIG_DATA_W-1:0] req_wdata,
  output logic [LANES-1:0] req_busy,
  output logic [LANES-1:0] resp_valid,
  output logic [LANES*phy_assist_pkg::RECONFIG_DATA_W-1:0] resp_rdata,
  output logic [LANES-1:0] power_ok
);
  import phy_assist_pkg::*;

  localparam int AW = RECONFIG_ADDR_W;
  localparam int DW = RECONFIG_DATA_W;

  logic [LANES-1:0] pok_meta_r;
  logic [LANES-1:0] pok_sync_r;

  function automatic logic is_hold_state(input link_state_e s);
    return (s == LS_RECOVERY_SPEED) || (s == LS_L1_ENTRY) || (s == LS_L1_IDLE) ||
           (s == LS_LOOPBACK_SPEED) || (s == LS_LOOPBACK_ENTRY);
  endfunction : is_hold_state

  // assist outputs are registered so they change only on mclk
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      link.mac_detect_state_flag <= 1'b0;
      link.clock_recovery_hold_request <= 1'b0;
      link.mac_link_active_flag <= 1'b0;
      link.rx_power_state_field <= RX_NOT_STANDBY;
    end else begin
      link.mac_detect_state_flag <= (link_state == LS_DETECT_QUIET) ||
                                    (link_state == LS_DETECT_ACTIVE);
      link.clock_recovery_hold_request <= is_hold_state(link_state);
      link.mac_link_active_flag <= (link_state == LS_L0);
      // outside L0 the field reads not-in-standby
      link.rx_power_state_field <= (link_state == LS_L0) ? rx_standby_state
                                                         : RX_NOT_STANDBY;
    end
  end

  // power-good is asynchronous to mclk
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      pok_meta_r <= '0;
      pok_sync_r <= '0;
      power_ok <= '0;
    end else begin
      pok_meta_r <= link.transceiver_power_ok;
      pok_sync_r <= pok_meta_r;
      power_ok <= pok_sync_r;
    end
  end

  genvar g;
  generate
    for (g = 0; g < LANES; g++) begin : g_lane
      always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
          link.reconfig_enable[g] <= 1'b0;
          link.reconfig_write_select[g] <= 1'b0;
          link.reconfig_addr[g*AW +: AW] <= '0;
          link.reconfig_write_data[g*DW +: DW] <= '0;
          req_busy[g] <= 1'b0;
          resp_valid[g] <= 1'b0;
          resp_rdata[g*DW +: DW] <= '0;
        end else begin
          link.reconfig_enable[g] <= 1'b0;
          resp_valid[g] <= 1'b0;
          // one access in flight; the next waits for ready
          if (!req_busy[g] && req_valid[g]) begin
            link.reconfig_enable[g] <= 1'b1;
            link.reconfig_write_select[g] <= req_write[g];
            link.reconfig_addr[g*AW +: AW] <= req_addr[g*AW +: AW];
            link.reconfig_write_data[g*DW +: DW] <= req_wdata[g*DW +: DW];
            req_busy[g] <= 1'b1;
          end else if (req_busy[g] && link.reconfig_ready[g]) begin
            req_busy[g] <= 1'b0;
            resp_valid[g] <= 1'b1;
            resp_rdata[g*DW +: DW] <= link.reconfig_read_data[g*DW +: DW];
          end
        end
      end
    end
  endgenerate
endmodule : phy_assist_mac_end
`default_nettype wire

// ==== rtl/phy_assist_phy_end.sv ====
// Purpose: PHY-side consumer of the assist sideband and reconfiguration slave
// Assumes: sideband inputs are produced on mclk by the MAC
// Notes: reconfiguration space is a plain register array per lane
// How it works
// - MAC raises detect flag in detect substates
// - termination follows the detect flag
// - MAC requests hold; PHY freezes clock recovery
// - MAC flags link active only in L0
// - link-active flag used only with standby support
// - receive power state coded zero to three
// - power state used only in L0, standby enabled
// - one shared power-good gates the reference clock buffer of every lane
// - MAC drives address, enable, select, write data
// - PHY returns ready and read data per lane
// - MAC maps its own states to assist outputs
`timescale 1ns/100ps
`default_nettype none
module phy_assist_phy_end #(
  parameter int LANES = phy_assist_pkg::LANES,
  parameter bit STANDBY_SUPPORTED = 1'b1
) (
  input wire logic mclk,
  input wire logic rst_b,
  phy_assist_if.phy link,
  output logic [LANES-1:0] term_to_gnd,
  output logic [LANES-1:0] cdr_hold,
  output logic [LANES-1:0] rx_standby_active,
  output logic [1:0] rx_standby_code,
  output logic [LANES-1:0] refclk_buf_enable
);
  import phy_assist_pkg::*;

  localparam int AW = RECONFIG_ADDR_W;
  localparam int DW = RECONFIG_DATA_W;
  // counter widths leave room for the end value itself
  localparam int PCW = $clog2(POWER_OK_CYCLES + 1);
  localparam int LCW = $clog2(RECONFIG_LATENCY + 1);

  logic [PCW-1:0] pok_cnt_r;
  logic pok_done;
  logic link_l0_used;
  logic state_valid;

  // the field only carries meaning in L0 with standby support built
  function automatic logic [1:0] standby_code(input logic valid, input logic [1:0] field);
    return valid ? field : RX_NOT_STANDBY;
  endfunction : standby_code

  // every code but not-in-standby names a standby substate
  function automatic logic standby_flag(input logic valid, input logic [1:0] field);
    return valid && (field != RX_NOT_STANDBY);
  endfunction : standby_flag

  // the active flag only counts when standby support is built
  assign link_l0_used = STANDBY_SUPPORTED ? link.mac_link_active_flag : 1'b0;
  assign state_valid = link_l0_used;

  // detect flag high selects the termination-to-ground setting
  // all lanes share one flag, so they switch together
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      term_to_gnd <= '0;
    end else begin
      term_to_gnd <= {LANES{link.mac_detect_state_flag}};
    end
  end

  // clock recovery stays frozen for as long as the request stands
  // lanes share one request because the MAC drives a single flag
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      cdr_hold <= '0;
    end else begin
      cdr_hold <= {LANES{link.clock_recovery_hold_request}};
    end
  end

  // a configuration without standby support never reports a standby state
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rx_standby_active <= '0;
    end else begin
      rx_standby_active <= {LANES{standby_flag(state_valid, link.rx_power_state_field)}};
    end
  end

  // outside L0 the code falls back to not-in-standby, whatever the field holds
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rx_standby_code <= RX_NOT_STANDBY;
    end else begin
      rx_standby_code <= standby_code(state_valid, link.rx_power_state_field);
    end
  end

  // power-good model: comes up a fixed time after reset release
  // the counter stops at its end value so the flag cannot wrap back
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      pok_cnt_r <= '0;
    end else if (!pok_done) begin
      pok_cnt_r <= pok_cnt_r + PCW'(1);
    end
  end

  assign pok_done = (pok_cnt_r == PCW'(POWER_OK_CYCLES));

  // power-good never falls again once up; only a reset takes it down
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      link.transceiver_power_ok <= '0;
    end else begin
      link.transceiver_power_ok <= {LANES{pok_done}};
    end
  end

  // the buffer enable is the power-good itself, one enable for all lanes
  // a flop of its own keeps the output straight from a register
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      refclk_buf_enable <= '0;
    end else begin
      refclk_buf_enable <= {LANES{pok_done}};
    end
  end

  genvar g;
  generate
    for (g = 0; g < LANES; g++) begin : g_lane
      logic [DW-1:0] mem_r [RECONFIG_WORDS];
      logic [LCW-1:0] lat_r;
      logic busy_r;
      logic wr_r;
      logic [AW-1:0] addr_r;
      logic [DW-1:0] wdata_r;
      logic start;
      logic finish;

      // an enable that arrives while busy is dropped, not queued
      assign start = !busy_r && link.reconfig_enable[g];
      // start needs the lane idle, so start and finish never fall in one cycle
      assign finish = busy_r && (lat_r == '0);

      // one access in flight per lane
      always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
          busy_r <= 1'b0;
        end else if (start) begin
          busy_r <= 1'b1;
        end else if (finish) begin
          busy_r <= 1'b0;
        end
      end

      // ready rises RECONFIG_LATENCY edges after the edge that takes the enable
      always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
          lat_r <= '0;
        end else if (start) begin
          lat_r <= LCW'(RECONFIG_LATENCY - 1);
        end else if (busy_r && (lat_r != '0)) begin
          lat_r <= lat_r - LCW'(1);
        end
      end

      // select, address and data are valid only beside the enable, so keep a copy
      always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
          wr_r <= 1'b0;
          addr_r <= '0;
          wdata_r <= '0;
        end else if (start) begin
          wr_r <= link.reconfig_write_select[g];
          addr_r <= link.reconfig_addr[g*AW +: AW];
          wdata_r <= link.reconfig_write_data[g*DW +: DW];
        end
      end

      // ready is a lone pulse, one per access
      always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
          link.reconfig_ready[g] <= 1'b0;
        end else begin
          link.reconfig_ready[g] <= finish;
        end
      end

      // read data moves only with ready and holds until the next one
      // a write answers with the reset word so stale data never looks fresh
      always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
          link.reconfig_read_data[g*DW +: DW] <= RECONFIG_RESET_WORD;
        end else if (finish) begin
          link.reconfig_read_data[g*DW +: DW] <= wr_r ? RECONFIG_RESET_WORD
                                                      : mem_r[addr_r];
        end
      end

      // storage has no reset; contents are undefined until written
      // so software must write a word before it reads it back
      always_ff @(posedge mclk) begin
        if (finish && wr_r) begin
          mem_r[addr_r] <= wdata_r;
        end
      end
    end
  endgenerate
endmodule : phy_assist_phy_end
`default_nettype wire

// ==== test/phy_assist_props.sv ====
// Purpose: wire-level checks of the assist sideband carrier
// Assumes: lane 0 watched, all signals sampled on mclk
// Notes: sees the carrier only, never the user sides of either end
`timescale 1ns/100ps
`default_nettype none
module phy_assist_props #(
  parameter int LANES = 1
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic mac_detect_state_flag,
  input wire logic clock_recovery_hold_request,
  input wire logic mac_link_active_flag,
  input wire logic [1:0] rx_power_state_field,
  input wire logic [LANES-1:0] transceiver_power_ok,
  input wire logic [LANES-1:0] reconfig_enable,
  input wire logic [LANES-1:0] reconfig_write_select,
  input wire logic [LANES-1:0] reconfig_ready,
  input wire logic [LANES*phy_assist_pkg::RECONFIG_DATA_W-1:0] reconfig_read_data
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  detect_not_l0_a: assert property (!(mac_detect_state_flag && mac_link_active_flag))
    else $error("detect flag high while link active");
  hold_not_l0_a: assert property (!(clock_recovery_hold_request && mac_link_active_flag))
    else $error("hold request high while link active");
  field_idle_a: assert property (!mac_link_active_flag |-> rx_power_state_field == 2'h0)
    else $error("power state field nonzero outside link active");
  enable_pulse_a: assert property (reconfig_enable[0] |=> !reconfig_enable[0] [*3])
    else $error("enable not a lone pulse");
  ready_time_a: assert property (reconfig_enable[0] |-> ##3 reconfig_ready[0])
    else $error("ready not three cycles after enable");
  ready_cause_a: assert property (reconfig_ready[0] |-> $past(reconfig_enable[0], 3))
    else $error("ready without an access");
  ready_pulse_a: assert property (reconfig_ready[0] |=> !reconfig_ready[0])
    else $error("ready longer than one cycle");
  write_zero_a: assert property (reconfig_ready[0] &&
    $past(reconfig_enable[0] && reconfig_write_select[0], 3) |-> reconfig_read_data == 16'h0000)
    else $error("write answered with nonzero data");
  data_hold_a: assert property (!reconfig_ready[0] |-> $stable(reconfig_read_data))
    else $error("read data moved without ready");
  power_keep_a: assert property (transceiver_power_ok[0] |=> transceiver_power_ok[0])
    else $error("power good dropped");
  read_c: cover property (reconfig_enable[0] && !reconfig_write_select[0]);
  write_c: cover property (reconfig_enable[0] && reconfig_write_select[0]);
  hold_c: cover property ($rose(clock_recovery_hold_request));
  field_c: cover property (mac_link_active_flag && rx_power_state_field == 2'h3);
endmodule : phy_assist_props
`default_nettype wire

// ==== test/pcie_phy_assist_sideband_tb.sv ====
// Purpose: drives both ends of the assist sideband and checks them
// Assumes: one lane; a second pair runs with standby support left out
// Notes: reads only touch written words, the space is not reset
`timescale 1ns/100ps
`default_nettype none
module pcie_phy_assist_sideband_tb;
  import phy_assist_pkg::*;
  logic mclk, rst_b, req_valid, req_write, req_busy, resp_valid, power_ok;
  logic term_to_gnd, cdr_hold, rx_standby_active, refclk_buf_enable, sb_active_ns;
  logic [1:0] rx_standby_state, rx_standby_code, sb_code_ns;
  logic [9:0] req_addr;
  logic [15:0] req_wdata, resp_rdata;
  logic [2:0] e;
  link_state_e link_state;
  int n_fail, num_checks, seed, i;
  logic [15:0] mem [int];
  phy_assist_if i_phy_assist_if (.mclk(mclk), .rst_b(rst_b));
  phy_assist_mac_end i_phy_assist_mac_end (.mclk(mclk), .rst_b(rst_b), .link(i_phy_assist_if),
    .link_state(link_state), .rx_standby_state(rx_standby_state), .req_valid(req_valid),
    .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata), .req_busy(req_busy),
    .resp_valid(resp_valid), .resp_rdata(resp_rdata), .power_ok(power_ok));
  phy_assist_phy_end i_phy_assist_phy_end (.mclk(mclk), .rst_b(rst_b), .link(i_phy_assist_if),
    .term_to_gnd(term_to_gnd), .cdr_hold(cdr_hold), .rx_standby_active(rx_standby_active),
    .rx_standby_code(rx_standby_code), .refclk_buf_enable(refclk_buf_enable));
  // a second pair built without standby support, driven by the same user side
  phy_assist_if i_phy_assist_if_ns (.mclk(mclk), .rst_b(rst_b));
  phy_assist_mac_end i_phy_assist_mac_end_ns (.mclk(mclk), .rst_b(rst_b),
    .link(i_phy_assist_if_ns), .link_state(link_state), .rx_standby_state(rx_standby_state),
    .req_valid(req_valid), .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
    .req_busy(), .resp_valid(), .resp_rdata(), .power_ok());
  phy_assist_phy_end #(.STANDBY_SUPPORTED(1'b0)) i_phy_assist_phy_end_ns (.mclk(mclk),
    .rst_b(rst_b), .link(i_phy_assist_if_ns), .term_to_gnd(), .cdr_hold(),
    .rx_standby_active(sb_active_ns), .rx_standby_code(sb_code_ns), .refclk_buf_enable());
  phy_assist_props i_phy_assist_props (.mclk(mclk), .rst_b(rst_b),
    .mac_detect_state_flag(i_phy_assist_if.mac_detect_state_flag),
    .clock_recovery_hold_request(i_phy_assist_if.clock_recovery_hold_request),
    .mac_link_active_flag(i_phy_assist_if.mac_link_active_flag),
    .rx_power_state_field(i_phy_assist_if.rx_power_state_field),
    .transceiver_power_ok(i_phy_assist_if.transceiver_power_ok),
    .reconfig_enable(i_phy_assist_if.reconfig_enable),
    .reconfig_write_select(i_phy_assist_if.reconfig_write_select),
    .reconfig_ready(i_phy_assist_if.reconfig_ready),
    .reconfig_read_data(i_phy_assist_if.reconfig_read_data));
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  task automatic end_of_test();
    if (n_fail == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : end_of_test
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  function automatic logic [2:0] flags(input link_state_e s);
    return {s inside {LS_DETECT_QUIET, LS_DETECT_ACTIVE}, s inside {LS_RECOVERY_SPEED,
      LS_L1_ENTRY, LS_L1_IDLE, LS_LOOPBACK_SPEED, LS_LOOPBACK_ENTRY}, s == LS_L0};
  endfunction : flags
  // request held through busy on purpose: the extra cycles must be ignored
  task automatic access(input logic w, input logic [9:0] a, input logic [15:0] d);
    int n;
    logic [15:0] x;
    x = w ? 16'h0000 : mem[a];
    @(posedge mclk);
    req_valid <= 1'b1;
    req_write <= w;
    req_addr <= a;
    req_wdata <= d;
    repeat (3) @(posedge mclk);
    req_valid <= 1'b0;
    n = 3;
    do begin
      @(posedge mclk);
      #1;
      n++;
    end while (!resp_valid && n < 12);
    if (resp_valid !== 1'b1) begin
      n_fail++;
      end_of_test();
    end
    chk("latency", 16'(RECONFIG_LATENCY + 3), 16'(n));
    chk("rdata", x, resp_rdata);
    if (w)
      mem[a] = d;
  endtask : access
  initial begin
    seed = 23;
    n_fail = 0;
    num_checks = 0;
    rst_b = 1'b0;
    req_valid = 1'b0;
    req_write = 1'b0;
    req_addr = 10'h000;
    req_wdata = 16'h0000;
    rx_standby_state = 2'h0;
    link_state = LS_POLLING;
    repeat (4) @(posedge mclk);
    rst_b <= 1'b1;
    i = 0;
    do begin
      @(posedge mclk);
      #1;
      i++;
    end while (power_ok !== 1'b1 && i < 20);
    chk("power delay", 16'(POWER_OK_CYCLES + 4), 16'(i));
    chk("refclk enable", 16'h0001, refclk_buf_enable);
    for (int k = 0; k < 52; k++) begin
      @(posedge mclk);
      link_state <= link_state_e'(k % 13);
      rx_standby_state <= 2'(k);
      repeat (2) @(posedge mclk);
      #1;
      e = flags(link_state);
      chk("detect wire", e[2], i_phy_assist_if.mac_detect_state_flag);
      chk("termination", e[2], term_to_gnd);
      chk("hold wire", e[1], i_phy_assist_if.clock_recovery_hold_request);
      chk("cdr hold", e[1], cdr_hold);
      chk("active wire", e[0], i_phy_assist_if.mac_link_active_flag);
      chk("standby active", 16'(e[0] && (rx_standby_state != RX_NOT_STANDBY)),
        rx_standby_active);
      chk("active no standby", 16'h0000, sb_active_ns);
      chk("code no standby", 16'h0000, sb_code_ns);
      chk("field", e[0] ? rx_standby_state : 2'h0, i_phy_assist_if.rx_power_state_field);
      chk("code", e[0] ? rx_standby_state : 2'h0, rx_standby_code);
    end
    access(1'b1, 10'h000, 16'hffff);
    access(1'b1, 10'h3ff, 16'ha5a5);
    for (int k = 0; k < 12; k++)
      access(1'b1, 10'($random(seed)), 16'($random(seed)));
    foreach (mem[a])
      access(1'b0, 10'(a), 16'h0000);
    end_of_test();
  end
endmodule : pcie_phy_assist_sideband_tb
`default_nettype wire
